//--- rtl/ssp_pkg.sv
/*
  Shared constants and types for the serial SRAM pause link.
  Assumes both ends run on one 200 MHz mclk.
*/
package ssp_pkg;
  localparam int CLK_NS        = 5;
  // Fastest legal serial clock period
  localparam int SCK_PERIOD_NS = 50;
  localparam int SCK_HALF_CYC  = ((SCK_PERIOD_NS / 2) + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] HALF_LAST = 4'(SCK_HALF_CYC - 1);

  localparam logic [7:0] CMD_READ  = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] CMD_RDSR  = 8'h05;
  localparam logic [7:0] CMD_WRSR  = 8'h01;

  localparam int         ST_HOLD_DIS_BIT = 0;
  localparam int         ST_MODE_LSB     = 6;
  localparam logic [7:0] STATUS_RST      = 8'h00;
  localparam logic [7:0] STATUS_WMASK    = 8'hc1;
  localparam logic [1:0] MODE_BYTE       = 2'h0;
  localparam logic [1:0] MODE_PAGE       = 2'h2;

  localparam int MEM_DEPTH = 32768;
  localparam int ADDR_W    = 15;

  typedef enum logic [6:0] {
    P_CMD  = 7'h01,
    P_ADDR = 7'h02,
    P_RD   = 7'h04,
    P_WR   = 7'h08,
    P_SRD  = 7'h10,
    P_SWR  = 7'h20,
    P_SKIP = 7'h40
  } ssp_phase_t;

  typedef enum logic [2:0] {
    H_IDLE = 3'h1,
    H_LOW  = 3'h2,
    H_HIGH = 3'h4
  } ssp_hst_t;
endpackage

//--- rtl/ssp_if.sv
/*
  Pin-level link between host and serial SRAM device.
  The host reads so as it is; nothing resolves the data pin from so_oe_b.
*/
`timescale 1ns/10ps
interface ssp_if;
  logic cs_b;
  logic sck;
  logic si;
  logic hold_b;
  logic so;
  logic so_oe_b;

  modport dev (
    input  cs_b,
    input  sck,
    input  si,
    input  hold_b,
    output so,
    output so_oe_b
  );

  modport host (
    output cs_b,
    output sck,
    output si,
    output hold_b,
    input  so,
    input  so_oe_b
  );
endinterface

//--- rtl/ssp_dev.sv
/*
  Serial SRAM device end: command decode, array, status and pause logic.
  Assumes link pins are asynchronous to mclk and the serial clock is
  at most a quarter of mclk.
*/
// How it works
// R1 - Host keeps pause high when not pausing
// R2 - Pause low suspends transfer, keeps sequence
// R3 - Pause taken while clock low, else next fall
// R4 - Host keeps select low through pause
// R5 - Paused: clock and data edges ignored
// R6 - Resume only with pause high, clock low
// R7 - Pause low floats data output unless disable bit set
// R8 - Status disable bit ignores pause input
// R9 - Status bit 0 is the pause disable
// R10 - Select low selects; high deselects, floats output
// R11 - Sample on rise, update output after fall
// R12 - Pause freezes counters, shifter, decode, address
`timescale 1ns/10ps
module ssp_dev
  import ssp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  ssp_if.dev              link,
  output logic            paused,
  output logic [7:0]      status
);

  logic [3:0]        s1_r;
  logic [3:0]        s2_r;
  logic              sck_d_r;
  logic [3:0]        s1_nxt;
  logic [3:0]        s2_nxt;
  logic              sck_d_nxt;

  ssp_phase_t        phase_r;
  ssp_phase_t        phase_nxt;
  logic [2:0]        bit_r;
  logic [2:0]        bit_nxt;
  logic [7:0]        sh_r;
  logic [7:0]        sh_nxt;
  logic              rd_cmd_r;
  logic              rd_cmd_nxt;
  logic              abyte_r;
  logic              abyte_nxt;
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [7:0]        tx_r;
  logic [7:0]        tx_nxt;
  logic              so_r;
  logic              so_nxt;
  logic              so_oe_b_r;
  logic              so_oe_b_nxt;
  logic [7:0]        status_r;
  logic [7:0]        status_nxt;
  logic              paused_r;
  logic              paused_nxt;

  logic [7:0]        mem_r [MEM_DEPTH];
  logic              mem_we;

  logic              cs_b_s;
  logic              sck_s;
  logic              si_s;
  logic              hold_b_s;
  logic              sel;
  logic              hold_low;
  logic              frozen;
  logic              act_rise;
  logic              act_fall;
  logic [7:0]        wbyte;
  logic [ADDR_W-1:0] addr_inc;
  logic [ADDR_W-1:0] addr_full;
  logic              one_byte;

  // Only s2_r and sck_d_r are read by logic; s1_r feeds nothing else
  always_comb begin
    s1_nxt    = {link.cs_b, link.sck, link.si, link.hold_b};
    s2_nxt    = s1_r;
    sck_d_nxt = s2_r[2];
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      // Idle pin levels, so no false clock edge follows reset
      s1_r    <= 4'h9;
      s2_r    <= 4'h9;
      sck_d_r <= 1'b0;
    end else begin
      s1_r    <= s1_nxt;
      s2_r    <= s2_nxt;
      sck_d_r <= sck_d_nxt;
    end
  end

  assign cs_b_s   = s2_r[3];
  assign sck_s    = s2_r[2];
  assign si_s     = s2_r[1];
  assign hold_b_s = s2_r[0];
  assign sel      = ~cs_b_s; // R10
  // Disable bit masks the pause pin completely
  assign hold_low = ~status_r[ST_HOLD_DIS_BIT] & ~hold_b_s; // R8 R9
  // A fall seen with pause low is itself swallowed
  assign frozen   = paused_r | (hold_low & ~sck_s); // R3 R5
  assign act_rise = sck_s & ~sck_d_r & ~frozen; // R11 R12
  assign act_fall = ~sck_s & sck_d_r & ~frozen; // R11 R12
  assign wbyte    = {sh_r[6:0], si_s};
  assign one_byte = status_r[ST_MODE_LSB +: 2] == MODE_BYTE;
  assign addr_inc = (status_r[ST_MODE_LSB +: 2] == MODE_PAGE) ?
                    {addr_r[14:5], 5'(addr_r[4:0] + 5'h01)} :
                    15'(addr_r + 15'h0001);
  assign addr_full = {addr_r[14:8], wbyte};

  always_comb begin
    if (!sel) begin
      paused_nxt = 1'b0;
    end else if (!paused_r) begin
      paused_nxt = hold_low & sel & ~sck_s; // R2 R3
    end else begin
      // Rise of pause while clock is high does not release
      paused_nxt = ~(~hold_low & ~sck_s); // R6
    end
  end

  always_comb begin
    phase_nxt  = phase_r;
    bit_nxt    = bit_r;
    sh_nxt     = sh_r;
    rd_cmd_nxt = rd_cmd_r;
    abyte_nxt  = abyte_r;
    addr_nxt   = addr_r;
    tx_nxt     = tx_r;
    so_nxt     = so_r;
    status_nxt = status_r;
    mem_we     = 1'b0;
    if (!sel) begin
      phase_nxt = P_CMD; // R10
      bit_nxt   = 3'h0;
      abyte_nxt = 1'b0;
    end else if (act_rise) begin
      bit_nxt = 3'(bit_r + 3'h1);
      sh_nxt  = wbyte;
      if (bit_r == 3'h7) begin
        case (phase_r)
          P_CMD: begin
            case (wbyte)
              CMD_READ, CMD_WRITE: begin
                phase_nxt  = P_ADDR;
                rd_cmd_nxt = wbyte == CMD_READ;
              end
              CMD_RDSR: begin
                phase_nxt = P_SRD;
                tx_nxt    = status_r;
              end
              CMD_WRSR: phase_nxt = P_SWR;
              default:  phase_nxt = P_SKIP;
            endcase
          end
          P_ADDR: begin
            if (!abyte_r) begin
              addr_nxt[14:8] = wbyte[6:0];
              abyte_nxt      = 1'b1;
            end else begin
              addr_nxt = addr_full;
              if (rd_cmd_r) begin
                phase_nxt = P_RD;
                tx_nxt    = mem_r[addr_full];
              end else begin
                phase_nxt = P_WR;
              end
            end
          end
          P_RD: begin
            addr_nxt  = addr_inc;
            tx_nxt    = mem_r[addr_inc];
            phase_nxt = one_byte ? P_SKIP : P_RD;
          end
          P_WR: begin
            mem_we    = 1'b1;
            addr_nxt  = addr_inc;
            phase_nxt = one_byte ? P_SKIP : P_WR;
          end
          P_SWR: begin
            status_nxt = wbyte & STATUS_WMASK; // R9
            phase_nxt  = P_SKIP;
          end
          P_SRD:   phase_nxt = P_SKIP;
          default: phase_nxt = P_SKIP;
        endcase
      end
    end else if (act_fall && (phase_r == P_RD || phase_r == P_SRD)) begin
      so_nxt = tx_r[7]; // R11
      tx_nxt = {tx_r[6:0], 1'b0};
    end
  end

  // Pause pin low with disable bit clear floats output at once, whatever the phase
  always_comb begin
    so_oe_b_nxt = ~(sel & ~paused_nxt & ~hold_low &
                    (phase_nxt == P_RD || phase_nxt == P_SRD)); // R5 R7 R10
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      phase_r   <= P_CMD;
      bit_r     <= 3'h0;
      sh_r      <= 8'h00;
      rd_cmd_r  <= 1'b0;
      abyte_r   <= 1'b0;
      addr_r    <= 15'h0000;
      tx_r      <= 8'h00;
      so_r      <= 1'b0;
      so_oe_b_r <= 1'b1;
      status_r  <= STATUS_RST;
      paused_r  <= 1'b0;
    end else begin
      phase_r   <= phase_nxt;
      bit_r     <= bit_nxt;
      sh_r      <= sh_nxt;
      rd_cmd_r  <= rd_cmd_nxt;
      abyte_r   <= abyte_nxt;
      addr_r    <= addr_nxt;
      tx_r      <= tx_nxt;
      so_r      <= so_nxt;
      so_oe_b_r <= so_oe_b_nxt;
      status_r  <= status_nxt;
      paused_r  <= paused_nxt;
    end
  end

  // Array is not reset; contents are undefined until written
  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem_r[addr_r] <= wbyte;
    end
  end

  assign link.so      = so_r;
  assign link.so_oe_b = so_oe_b_r;
  assign paused       = paused_r;
  assign status       = status_r;

endmodule // ssp_dev

//--- rtl/ssp_host.sv
/*
  Host end: makes the serial clock by division, shifts bytes, pauses.
  Assumes user requests on mclk and device data output arriving
  asynchronously.
*/
`timescale 1ns/10ps
module ssp_host
  import ssp_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_b,
  ssp_if.host             link,
  input  wire logic       frame_en,
  input  wire logic       go,
  input  wire logic [7:0] tx_byte,
  input  wire logic       pause_req,
  output logic [7:0]      rx_byte,
  output logic            byte_done,
  output logic            busy,
  output logic            paused
);

  ssp_hst_t   st_r;
  ssp_hst_t   st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [2:0] bit_r;
  logic [2:0] bit_nxt;
  logic [7:0] txs_r;
  logic [7:0] txs_nxt;
  logic [7:0] rxs_r;
  logic [7:0] rxs_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic       sck_r;
  logic       sck_nxt;
  logic       si_r;
  logic       si_nxt;
  logic       cs_b_r;
  logic       cs_b_nxt;
  logic       hold_b_r;
  logic       hold_b_nxt;
  logic       done_r;
  logic       done_nxt;
  logic       busy_r;
  logic       busy_nxt;
  logic       paused_r;
  logic       paused_nxt;
  logic       so_s1_r;
  logic       so_s2_r;

  always_comb begin
    st_nxt     = st_r;
    cnt_nxt    = cnt_r;
    bit_nxt    = bit_r;
    txs_nxt    = txs_r;
    rxs_nxt    = rxs_r;
    rx_nxt     = rx_r;
    sck_nxt    = sck_r;
    si_nxt     = si_r;
    cs_b_nxt   = cs_b_r;
    hold_b_nxt = hold_b_r;
    done_nxt   = 1'b0;
    paused_nxt = paused_r;
    // Pause pin moves only while the clock is low
    if (!paused_r && pause_req && !cs_b_r && st_r != H_HIGH) begin
      hold_b_nxt = 1'b0; // R2 R3
      paused_nxt = 1'b1;
    end else if (paused_r && !pause_req) begin
      hold_b_nxt = 1'b1; // R1 R6
      paused_nxt = 1'b0;
      cnt_nxt    = 4'h0;
    end
    case (st_r)
      H_IDLE: begin
        // Select is held through a pause
        if (!paused_r && !paused_nxt) begin
          cs_b_nxt = ~frame_en; // R4
        end
        if (go && frame_en && !cs_b_r && !paused_r) begin
          st_nxt  = H_LOW;
          cnt_nxt = 4'h0;
          bit_nxt = 3'h0;
          txs_nxt = tx_byte;
          si_nxt  = tx_byte[7];
        end
      end
      H_LOW: begin
        if (!paused_r && paused_nxt == paused_r) begin
          if (cnt_r == HALF_LAST) begin
            sck_nxt = 1'b1;
            st_nxt  = H_HIGH;
            cnt_nxt = 4'h0;
          end else begin
            cnt_nxt = 4'(cnt_r + 4'h1);
          end
        end
      end
      H_HIGH: begin
        if (cnt_r == HALF_LAST) begin
          // Sampled late in the high half, long after device update
          rxs_nxt = {rxs_r[6:0], so_s2_r};
          sck_nxt = 1'b0;
          cnt_nxt = 4'h0;
          if (bit_r == 3'h7) begin
            st_nxt   = H_IDLE;
            rx_nxt   = {rxs_r[6:0], so_s2_r};
            done_nxt = 1'b1;
          end else begin
            st_nxt  = H_LOW;
            bit_nxt = 3'(bit_r + 3'h1);
            txs_nxt = {txs_r[6:0], 1'b0};
            si_nxt  = txs_r[6];
          end
        end else begin
          cnt_nxt = 4'(cnt_r + 4'h1);
        end
      end
      default: st_nxt = H_IDLE;
    endcase
    busy_nxt = st_nxt != H_IDLE;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      st_r     <= H_IDLE;
      cnt_r    <= 4'h0;
      bit_r    <= 3'h0;
      txs_r    <= 8'h00;
      rxs_r    <= 8'h00;
      rx_r     <= 8'h00;
      sck_r    <= 1'b0;
      si_r     <= 1'b0;
      cs_b_r   <= 1'b1;
      hold_b_r <= 1'b1;
      done_r   <= 1'b0;
      busy_r   <= 1'b0;
      paused_r <= 1'b0;
      so_s1_r  <= 1'b0;
      so_s2_r  <= 1'b0;
    end else begin
      st_r     <= st_nxt;
      cnt_r    <= cnt_nxt;
      bit_r    <= bit_nxt;
      txs_r    <= txs_nxt;
      rxs_r    <= rxs_nxt;
      rx_r     <= rx_nxt;
      sck_r    <= sck_nxt;
      si_r     <= si_nxt;
      cs_b_r   <= cs_b_nxt;
      hold_b_r <= hold_b_nxt;
      done_r   <= done_nxt;
      busy_r   <= busy_nxt;
      paused_r <= paused_nxt;
      so_s1_r  <= link.so;
      so_s2_r  <= so_s1_r;
    end
  end

  assign link.cs_b   = cs_b_r;
  assign link.sck    = sck_r;
  assign link.si     = si_r;
  assign link.hold_b = hold_b_r;
  assign rx_byte     = rx_r;
  assign byte_done   = done_r;
  assign busy        = busy_r;
  assign paused      = paused_r;

endmodule // ssp_host

//--- verification/ssp_link_props.sv
/*
  Concurrent checks on the pause link pins between host and device.
  Assumes one mclk domain and the device status byte as an extra input.
*/
`timescale 1ns/10ps
module ssp_link_props (
  input wire logic       mclk,
  input wire logic       rst_b,
  input wire logic       cs_b,
  input wire logic       sck,
  input wire logic       si,
  input wire logic       hold_b,
  input wire logic       so,
  input wire logic       so_oe_b,
  input wire logic [7:0] status
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  // Margin covers the two-flop pin sampling
  sequence s_hold_held;
    (!hold_b && !cs_b && !status[0])[*5];
  endsequence

  sequence s_deselected;
    cs_b[*5];
  endsequence

  sequence s_hold_kept;
    !hold_b ##1 !hold_b;
  endsequence

  a_pause_floats: assert property (s_hold_held |-> so_oe_b)
    else $error("data out driven while paused");
  a_deselect_float: assert property (s_deselected |-> so_oe_b)
    else $error("data out driven while deselected");
  a_select_in_hold: assert property (!hold_b |-> !cs_b)
    else $error("pause outside a selected frame");
  a_hold_fall_low: assert property ($fell(hold_b) |-> !sck)
    else $error("pause entered with clock high");
  a_hold_rise_low: assert property ($rose(hold_b) |-> !sck)
    else $error("resume with clock high");
  a_pins_frozen: assert property (
    s_hold_kept |-> $stable(sck) && $stable(si))
    else $error("clock or data moved while paused");
  a_idle_clock_low: assert property (cs_b |-> !sck)
    else $error("clock runs while deselected");
  a_high_half_len: assert property (
    $rose(sck) |-> sck[*5] ##1 !sck)
    else $error("clock high half not five cycles");
  a_out_after_fall: assert property (
    $changed(so) && !so_oe_b |-> !sck)
    else $error("data out changed with clock high");
  a_paused_out_still: assert property (s_hold_held |-> $stable(so))
    else $error("data out moved while paused");
endmodule // ssp_link_props

//--- verification/tb_serial_sram_pause_control.sv
/*
  Bench for host and device ends joined on one link: status writes,
  pause in mid-byte of status, address and data, and the pause-disable bit.
  Assumes the rtl package, interface and both ends compiled first.
*/
`timescale 1ns/10ps
module tb_serial_sram_pause_control;
  import ssp_pkg::*;
  logic       mclk;
  logic       rst_b;
  logic       frame_en;
  logic       go;
  logic [7:0] tx_byte;
  logic       pause_req;
  logic [7:0] rx_byte;
  logic       byte_done;
  logic       busy;
  logic       host_paused;
  logic       dev_paused;
  logic [7:0] status;
  int         fails;
  int         samples_checked;

  ssp_if link_if ();
  ssp_dev ssp_dev_inst (.mclk(mclk), .rst_b(rst_b), .link(link_if),
    .paused(dev_paused), .status(status));
  ssp_host ssp_host_inst (.mclk(mclk), .rst_b(rst_b), .link(link_if),
    .frame_en(frame_en), .go(go), .tx_byte(tx_byte),
    .pause_req(pause_req), .rx_byte(rx_byte), .byte_done(byte_done),
    .busy(busy), .paused(host_paused));
  ssp_link_props ssp_link_props_inst (.mclk(mclk), .rst_b(rst_b),
    .cs_b(link_if.cs_b), .sck(link_if.sck), .si(link_if.si),
    .hold_b(link_if.hold_b), .so(link_if.so),
    .so_oe_b(link_if.so_oe_b), .status(status));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  // One byte; optional pause after pdly cycles, expected pause answers
  task automatic xfer(input logic [7:0] tx, input int pdly = 0,
                      input logic ep = 1'b1, input logic eo = 1'b1);
    int n;
    @(posedge mclk);
    tx_byte <= tx;
    go      <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    @(negedge mclk);
    chk({7'h00, busy}, 8'h01);
    if (pdly > 0) begin
      repeat (pdly) @(posedge mclk);
      pause_req <= 1'b1;
      repeat (12) @(negedge mclk);
      chk({7'h00, dev_paused}, {7'h00, ep});
      chk({7'h00, link_if.so_oe_b}, {7'h00, eo});
      chk({7'h00, host_paused}, 8'h01);
      chk({7'h00, busy}, 8'h01);
      @(posedge mclk);
      pause_req <= 1'b0;
    end
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (byte_done !== 1'b1 && n < 400);
    chk({7'h00, byte_done}, 8'h01);
    chk({7'h00, busy}, 8'h00);
  endtask

  task automatic open_frame();
    @(posedge mclk);
    frame_en <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask

  task automatic close_frame();
    @(posedge mclk);
    frame_en <= 1'b0;
    repeat (6) @(negedge mclk);
    chk({7'h00, link_if.cs_b}, 8'h01);
    chk({7'h00, link_if.so_oe_b}, 8'h01);
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    fails++;
    give_verdict();
  end

  initial begin
    rst_b     = 1'b0;
    frame_en  = 1'b0;
    go        = 1'b0;
    tx_byte   = 8'h00;
    pause_req = 1'b0;
    fails = 0;
    samples_checked = 0;
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    @(negedge mclk);
    chk({7'h00, link_if.hold_b}, 8'h01);
    chk({7'h00, link_if.so_oe_b}, 8'h01);
    chk(status, STATUS_RST);
    // Status write paused mid-byte must still land, masked
    open_frame();
    xfer(CMD_WRSR);
    xfer(8'hff, 30);
    close_frame();
    chk(status, 8'hc1);
    // Disable bit set: pause pin ignored while status shifts out
    open_frame();
    xfer(CMD_RDSR);
    xfer(8'h00, 30, 1'b0, 1'b0);
    chk(rx_byte, 8'hc1);
    close_frame();
    open_frame();
    xfer(CMD_WRSR);
    xfer(8'h00);
    close_frame();
    chk(status, 8'h00);
    // Pauses inside the address and the data byte of a write
    open_frame();
    xfer(CMD_WRITE);
    xfer(8'h00);
    xfer(8'h10, 45);
    xfer(8'ha5, 15);
    close_frame();
    open_frame();
    xfer(CMD_READ);
    xfer(8'h00, 5);
    xfer(8'h10);
    xfer(8'h00, 55);
    chk(rx_byte, 8'ha5);
    close_frame();
    // Page mode: two bytes at the page end wrap to its start
    open_frame();
    xfer(CMD_WRSR);
    xfer(8'h80);
    close_frame();
    chk(status, 8'h80);
    open_frame();
    xfer(CMD_WRITE);
    xfer(8'h00);
    xfer(8'h1f);
    xfer(8'h11);
    xfer(8'h22, 25);
    close_frame();
    // Read left driving, so the deselect float is really exercised
    open_frame();
    xfer(CMD_READ);
    xfer(8'h00);
    xfer(8'h1f);
    chk({7'h00, link_if.so_oe_b}, 8'h00);
    xfer(8'h00, 35);
    chk(rx_byte, 8'h11);
    xfer(8'h00);
    chk(rx_byte, 8'h22);
    close_frame();
    give_verdict();
  end
endmodule // tb_serial_sram_pause_control
